// *** pulse_bank_pkg.sv ***
// Purpose: Shared constants and types of the pulse output status bank
// Assumes: Register indices times four give the APB byte address
// Notes:   Sixteen-bit registers sit in the low half of each word
package pulse_bank_pkg;
  localparam int          NCH     = 4;
  localparam int          ADDR_W  = 12;
  localparam logic [31:0] PV_MAX  = 32'h7FFFFFFF;
  localparam logic [31:0] PV_MIN  = 32'h80000000;
  localparam logic [31:0] PV_RST  = 32'h00000000;

  // Register indices, element [0] is channel 0
  localparam logic [3:0][9:0] IDX_POS_LO = {10'h144, 10'h142, 10'h116, 10'h114};
  localparam logic [3:0][9:0] IDX_POS_HI = {10'h145, 10'h143, 10'h117, 10'h115};
  localparam logic [3:0][9:0] IDX_STAT   = {10'h147, 10'h146, 10'h119, 10'h118};
  localparam logic [3:0][9:0] IDX_ERR    = {10'h1B7, 10'h1B6, 10'h1BD, 10'h1BC};
  localparam logic [3:0][9:0] IDX_CLR    = {10'h21F, 10'h21E, 10'h21D, 10'h21C};
  localparam logic [9:0]      IDX_CFG    = 10'h220;
  localparam logic [9:0]      IDX_IST    = 10'h221;
  localparam logic [9:0]      IDX_IMASK  = 10'h222;

  // Status word bits
  localparam int ST_ACCEL = 0;
  localparam int ST_OVF   = 1;
  localparam int ST_AMT   = 2;
  localparam int ST_DONE  = 3;
  localparam int ST_BUSY  = 4;
  localparam int ST_NOORG = 5;
  localparam int ST_ATORG = 6;
  localparam int ST_SERR  = 7;
  localparam logic [7:0] FLAGS_RST = 8'h60;

  // Clear and inputs word bits
  localparam int CL_CLEAR = 0;
  localparam int CL_CW    = 8;
  localparam int CL_CCW   = 9;
  localparam int CL_PDONE = 10;

  // Configuration bits
  localparam int         CFG_CNT_EN = 0;
  localparam int         CFG_ORG_EN = 1;
  localparam logic [1:0] CFG_RST    = 2'h0;

  // Interrupt event groups, bit = group * NCH + channel
  localparam int          EV_OVF    = 0;
  localparam int          EV_DONE   = 1;
  localparam int          EV_SERR   = 2;
  localparam logic [11:0] IMASK_RST = 12'h000;

  // Input word one bit assignment
  localparam int IW1_CNT3_Z = 0;
  localparam int IW1_ORG2   = 1;
  localparam int IW1_ORG1   = 2;
  localparam int IW1_ORG0   = 3;

  localparam logic [15:0] SERR_FALLBACK = 16'h0001;

  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_ACK  = 1'b1
  } bus_state_e;

  typedef struct packed {
    logic        step;
    logic        dir_ccw;
    logic        accel;
    logic        busy;
    logic        count_set;
    logic        count_done;
    logic        origin_found;
    logic        stop_err;
    logic [15:0] stop_code;
  } chan_in_s;

  typedef struct packed {
    bus_state_e       bus;
    logic             pready;
    logic             pslverr;
    logic [31:0]      prdata;
    logic [3:0][31:0] pv;
    logic [3:0][7:0]  flags;
    logic [3:0][15:0] errcode;
    logic [3:0]       clr;
    logic [15:0]      pin_s1;
    logic [15:0]      pin_s2;
    logic [1:0]       cfg;
    logic [11:0]      ist;
    logic [11:0]      imask;
    logic             irq;
    logic [3:0]       origin_sense;
    logic             cnt3_reset;
  } bank_state_s;
endpackage : pulse_bank_pkg

// *** pulse_output_status_bank.sv ***
// Purpose: Present counts, flags and clear control of four pulse outputs
// Assumes: Motion engine inputs are on pclk; limit and input pins are not
// Notes:   APB slave with one wait state; interrupt from sticky events
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
module pulse_output_status_bank (
  input  wire logic                                pclk,
  input  wire logic                                presetn,
  input  wire logic                                psel,
  input  wire logic                                penable,
  input  wire logic                                pwrite,
  input  wire logic [pulse_bank_pkg::ADDR_W-1:0]   paddr,
  input  wire logic [31:0]                         pwdata,
  input  wire logic [3:0]                          pstrb,
  output logic      [31:0]                         prdata,
  output logic                                     pready,
  output logic                                     pslverr,
  input  wire pulse_bank_pkg::chan_in_s [3:0]      chan_in,
  input  wire logic [3:0]                          cw_limit,
  input  wire logic [3:0]                          ccw_limit,
  input  wire logic [3:0]                          pos_complete,
  input  wire logic [3:0]                          input_word_one,
  output logic      [3:0]                          origin_sense,
  output logic                                     counter3_reset,
  output logic                                     irq
);
  pulse_bank_pkg::bank_state_s q;
  pulse_bank_pkg::bank_state_s d;
  logic [9:0]  idx;
  logic        wr;
  logic [15:0] wd;
  logic [3:0]  clr_rise;
  logic [11:0] ev;
  logic [32:0] rd;

  // Returns hit flag and read word for one register index
  function automatic logic [32:0] read_reg(
    input pulse_bank_pkg::bank_state_s s,
    input logic [9:0]                  i
  );
    logic [32:0] r;
    r = '0;
    for (int c = 0; c < pulse_bank_pkg::NCH; c++) begin
      if (i == pulse_bank_pkg::IDX_POS_LO[c]) begin
        r = {1'h1, 16'h0000, s.pv[c][15:0]};
      end
      if (i == pulse_bank_pkg::IDX_POS_HI[c]) begin
        r = {1'h1, 16'h0000, s.pv[c][31:16]};
      end
      if (i == pulse_bank_pkg::IDX_STAT[c]) begin
        r = {1'h1, 24'h000000, s.flags[c]};
      end
      if (i == pulse_bank_pkg::IDX_ERR[c]) begin
        r = {1'h1, 16'h0000, s.errcode[c]};
      end
      if (i == pulse_bank_pkg::IDX_CLR[c]) begin
        r = {1'h1, 16'h0000, 5'h00, s.pin_s2[8+c], s.pin_s2[4+c],
             s.pin_s2[c], 7'h00, s.clr[c]};
      end
    end
    if (i == pulse_bank_pkg::IDX_CFG) begin
      r = {1'h1, 30'h00000000, s.cfg};
    end
    if (i == pulse_bank_pkg::IDX_IST) begin
      r = {1'h1, 20'h00000, s.ist};
    end
    if (i == pulse_bank_pkg::IDX_IMASK) begin
      r = {1'h1, 20'h00000, s.imask};
    end
    return r;
  endfunction : read_reg

  assign idx = paddr[pulse_bank_pkg::ADDR_W-1:2];
  assign rd  = read_reg(q, idx);
  assign wd  = pwdata[15:0] & {{8{pstrb[1]}}, {8{pstrb[0]}}};
  // Write lands on the edge that sees pready high
  assign wr  = (q.bus == pulse_bank_pkg::BUS_ACK) && psel && penable
               && pwrite && !q.pslverr;

  always_comb begin
    d = q;
    clr_rise = '0;
    ev = '0;
    // Pins pass two flops before any use
    d.pin_s1 = {input_word_one, pos_complete, ccw_limit, cw_limit};
    d.pin_s2 = q.pin_s1;

    case (q.bus)
      pulse_bank_pkg::BUS_IDLE: begin
        if (psel && penable) begin
          d.pready  = 1'h1;
          d.pslverr = !rd[32] || (paddr[1:0] != 2'h0);
          d.prdata  = rd[32] ? rd[31:0] : 32'h00000000;
          d.bus     = pulse_bank_pkg::BUS_ACK;
        end
      end
      pulse_bank_pkg::BUS_ACK: begin
        d.pready  = 1'h0;
        d.pslverr = 1'h0;
        d.prdata  = 32'h00000000;
        d.bus     = pulse_bank_pkg::BUS_IDLE;
      end
      default: begin
        d.bus = pulse_bank_pkg::BUS_IDLE;
      end
    endcase

    if (wr) begin
      for (int c = 0; c < pulse_bank_pkg::NCH; c++) begin
        if (idx == pulse_bank_pkg::IDX_CLR[c] && pstrb[0]) begin
          d.clr[c]    = wd[pulse_bank_pkg::CL_CLEAR];
          clr_rise[c] = wd[pulse_bank_pkg::CL_CLEAR] && !q.clr[c];
        end
      end
      if (idx == pulse_bank_pkg::IDX_CFG && pstrb[0]) begin
        d.cfg = wd[1:0];
      end
      if (idx == pulse_bank_pkg::IDX_IMASK) begin
        d.imask = (q.imask & ~{{4{pstrb[1]}}, {8{pstrb[0]}}}) | wd[11:0];
      end
    end

    // Each channel touches only its own slice
    for (int c = 0; c < pulse_bank_pkg::NCH; c++) begin
      if (clr_rise[c]) begin
        d.pv[c] = pulse_bank_pkg::PV_RST;
        d.flags[c][pulse_bank_pkg::ST_OVF] = 1'h0;
      end else if (chan_in[c].step) begin
        if (chan_in[c].dir_ccw) begin
          d.pv[c] = q.pv[c] - 32'h00000001;
          if (q.pv[c] == pulse_bank_pkg::PV_MIN) begin
            d.flags[c][pulse_bank_pkg::ST_OVF] = 1'h1;
            ev[pulse_bank_pkg::EV_OVF*4+c] = 1'h1;
          end
        end else begin
          d.pv[c] = q.pv[c] + 32'h00000001;
          if (q.pv[c] == pulse_bank_pkg::PV_MAX) begin
            d.flags[c][pulse_bank_pkg::ST_OVF] = 1'h1;
            ev[pulse_bank_pkg::EV_OVF*4+c] = 1'h1;
          end
        end
      end

      d.flags[c][pulse_bank_pkg::ST_ACCEL] = chan_in[c].accel;
      d.flags[c][pulse_bank_pkg::ST_BUSY]  = chan_in[c].busy;

      // A new count restarts the completion cycle
      if (chan_in[c].count_set) begin
        d.flags[c][pulse_bank_pkg::ST_AMT]  = 1'h1;
        d.flags[c][pulse_bank_pkg::ST_DONE] = 1'h0;
      end
      if (chan_in[c].count_done) begin
        d.flags[c][pulse_bank_pkg::ST_DONE] = 1'h1;
        d.flags[c][pulse_bank_pkg::ST_AMT]  = 1'h0;
        ev[pulse_bank_pkg::EV_DONE*4+c] = 1'h1;
      end

      if (chan_in[c].origin_found) begin
        d.flags[c][pulse_bank_pkg::ST_NOORG] = 1'h0;
      end

      // Stopped means no pulses pending in the same cycle
      d.flags[c][pulse_bank_pkg::ST_ATORG] =
        (d.pv[c] == pulse_bank_pkg::PV_RST) && !chan_in[c].busy;

      // Error holds; only a new search result or clear drops it, and a new error wins
      if (chan_in[c].stop_err) begin
        d.flags[c][pulse_bank_pkg::ST_SERR] = 1'h1;
        d.errcode[c] = (chan_in[c].stop_code != 16'h0000) ?
                       chan_in[c].stop_code : pulse_bank_pkg::SERR_FALLBACK;
        ev[pulse_bank_pkg::EV_SERR*4+c] = 1'h1;
      end else if (chan_in[c].origin_found || clr_rise[c]) begin
        d.flags[c][pulse_bank_pkg::ST_SERR] = 1'h0;
        d.errcode[c] = 16'h0000;
      end
    end

    // Set wins over a same-cycle write-one-to-clear
    if (wr && idx == pulse_bank_pkg::IDX_IST) begin
      d.ist = q.ist & ~(wd[11:0] & {{4{pstrb[1]}}, {8{pstrb[0]}}});
    end
    d.ist = d.ist | ev;
    d.irq = |(d.ist & d.imask);

    // Input word one routing, gated by mode enables
    d.cnt3_reset = q.cfg[pulse_bank_pkg::CFG_CNT_EN] &&
                   q.pin_s2[12+pulse_bank_pkg::IW1_CNT3_Z];
    d.origin_sense[3] = q.cfg[pulse_bank_pkg::CFG_ORG_EN] &&
                        q.pin_s2[12+pulse_bank_pkg::IW1_CNT3_Z];
    d.origin_sense[2] = q.cfg[pulse_bank_pkg::CFG_ORG_EN] &&
                        q.pin_s2[12+pulse_bank_pkg::IW1_ORG2];
    d.origin_sense[1] = q.cfg[pulse_bank_pkg::CFG_ORG_EN] &&
                        q.pin_s2[12+pulse_bank_pkg::IW1_ORG1];
    d.origin_sense[0] = q.cfg[pulse_bank_pkg::CFG_ORG_EN] &&
                        q.pin_s2[12+pulse_bank_pkg::IW1_ORG0];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q       <= '0;
      q.flags <= {4{pulse_bank_pkg::FLAGS_RST}};
      q.cfg   <= pulse_bank_pkg::CFG_RST;
      q.imask <= pulse_bank_pkg::IMASK_RST;
    end else begin
      q <= d;
    end
  end

  assign prdata         = q.prdata;
  assign pready         = q.pready;
  assign pslverr        = q.pslverr;
  assign origin_sense   = q.origin_sense;
  assign counter3_reset = q.cnt3_reset;
  assign irq            = q.irq;

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_access;
    psel && penable && !q.pready && (q.bus == pulse_bank_pkg::BUS_IDLE);
  endsequence

  sequence s_clear0;
    wr && idx == pulse_bank_pkg::IDX_CLR[0] && pstrb[0] && wd[0] && !q.clr[0];
  endsequence

  AST_APB_ONE_WAIT: assert property (s_access |=> q.pready ##1 !q.pready)
    else $error("APB answer not after one wait");

  AST_PV_CLEAR: assert property (s_clear0 |=> q.pv[0] == 32'h00000000)
    else $error("Count not cleared on clear edge");

  AST_PV_STEP: assert property (chan_in[1].step && !chan_in[1].dir_ccw && !clr_rise[1]
    |=> q.pv[1] == $past(q.pv[1]) + 32'h00000001)
    else $error("Count did not advance");

  AST_CW_FLAG: assert property (##3 rd[32] && idx == pulse_bank_pkg::IDX_CLR[0]
    |-> rd[pulse_bank_pkg::CL_CW] == $past(cw_limit[0], 2))
    else $error("Clockwise flag wrong");

  AST_CCW_FLAG: assert property (q.pin_s2[4+2] == $past(ccw_limit[2], 2))
    else $error("Counterclockwise flag wrong");

  AST_PDONE_FLAG: assert property (q.pin_s2[8+3] == $past(pos_complete[3], 2))
    else $error("Positioning completed flag wrong");

  AST_ACCEL: assert property (q.flags[0][pulse_bank_pkg::ST_ACCEL]
    == $past(chan_in[0].accel))
    else $error("Accel flag wrong");

  AST_OVF: assert property (chan_in[2].step && !chan_in[2].dir_ccw && !clr_rise[2]
    && q.pv[2] == pulse_bank_pkg::PV_MAX
    |=> q.flags[2][pulse_bank_pkg::ST_OVF] && q.pv[2] == pulse_bank_pkg::PV_MIN)
    else $error("Overflow not flagged");

  AST_AMT: assert property (chan_in[1].count_set && !chan_in[1].count_done
    |=> q.flags[1][pulse_bank_pkg::ST_AMT] && !q.flags[1][pulse_bank_pkg::ST_DONE])
    else $error("Amount set flag wrong");

  AST_DONE: assert property (chan_in[3].count_done
    |=> q.flags[3][pulse_bank_pkg::ST_DONE] ##1 q.ist[pulse_bank_pkg::EV_DONE*4+3]
    || $past(wr))
    else $error("Completion not flagged");

  AST_BUSY: assert property (q.flags[2][pulse_bank_pkg::ST_BUSY]
    == $past(chan_in[2].busy))
    else $error("Busy flag wrong");

  AST_NOORG: assert property (chan_in[0].origin_found
    |=> !q.flags[0][pulse_bank_pkg::ST_NOORG])
    else $error("No-origin flag stuck");

  AST_ATORG: assert property (q.flags[3][pulse_bank_pkg::ST_ATORG]
    == (q.pv[3] == 32'h00000000 && !q.flags[3][pulse_bank_pkg::ST_BUSY]))
    else $error("At-origin flag wrong");

  AST_SERR: assert property (chan_in[1].stop_err
    |=> q.flags[1][pulse_bank_pkg::ST_SERR] && q.errcode[1] != 16'h0000)
    else $error("Stop error not flagged");

  AST_ERRCODE: assert property ((q.errcode[2] != 16'h0000)
    == q.flags[2][pulse_bank_pkg::ST_SERR])
    else $error("Error code disagrees with flag");

  AST_CNT3: assert property (counter3_reset == ($past(q.cfg[0])
    && $past(input_word_one[0], 3)))
    else $error("Counter three reset misrouted");

  AST_ORG2: assert property (origin_sense[2] == ($past(q.cfg[1])
    && $past(input_word_one[1], 3)))
    else $error("Channel 2 origin misrouted");

  AST_IRQ: assert property (irq == |(q.ist & q.imask))
    else $error("Interrupt disagrees with status");
endmodule : pulse_output_status_bank

// *** pulse_drive_model.sv ***
// Purpose: Motor drive, limit and origin sensor model for the status bank
// Assumes: Everything changes just after a rising pclk edge
// Notes:   Stop code is inverted after its strobe, so a late sample sees a wrong code
`timescale 1ns/1ps
module pulse_drive_model (
  input  wire logic                      pclk,
  output pulse_bank_pkg::chan_in_s [3:0] chan_in,
  output logic [3:0]                     cw_limit,
  output logic [3:0]                     ccw_limit,
  output logic [3:0]                     pos_complete,
  output logic [3:0]                     input_word_one
);
  logic [3:0] org_q;

  // Origin sensors land on fixed bits of input word one
  assign input_word_one[0] = org_q[3];
  assign input_word_one[1] = org_q[2];
  assign input_word_one[2] = org_q[1];
  assign input_word_one[3] = org_q[0];

  initial begin
    chan_in = '0;
    cw_limit = '0;
    ccw_limit = '0;
    pos_complete = '0;
    org_q = '0;
  end

  // Gap between steps lets the drive run fast or slow
  task move(input int c, input int k, input logic counterclockwise_direction, input int gap);
    @(posedge pclk);
    chan_in[c].busy <= 1'b1;
    chan_in[c].accel <= 1'b1;
    chan_in[c].dir_ccw <= counterclockwise_direction;
    for (int i = 0; i < k; i++) begin
      @(posedge pclk);
      chan_in[c].step <= 1'b1;
      @(posedge pclk);
      chan_in[c].step <= 1'b0;
      repeat (gap) @(posedge pclk);
    end
    chan_in[c].busy <= 1'b0;
    chan_in[c].accel <= 1'b0;
    chan_in[c].count_done <= 1'b1;
    @(posedge pclk);
    chan_in[c].count_done <= 1'b0;
  endtask : move

  // Kind 0 count loaded, 1 origin found, 2 stop error
  task ev(input int c, input int k, input logic [15:0] code);
    @(posedge pclk);
    chan_in[c].count_set <= (k == 0);
    chan_in[c].origin_found <= (k == 1);
    chan_in[c].stop_err <= (k == 2);
    chan_in[c].stop_code <= code;
    @(posedge pclk);
    chan_in[c].count_set <= 1'b0;
    chan_in[c].origin_found <= 1'b0;
    chan_in[c].stop_err <= 1'b0;
    chan_in[c].stop_code <= ~code;
  endtask : ev

  task level(input int c, input logic acc, input logic bsy);
    @(posedge pclk);
    chan_in[c].accel <= acc;
    chan_in[c].busy <= bsy;
  endtask : level

  task pins(input logic [3:0] cw, input logic [3:0] counterclockwise_direction, input logic [3:0] pc);
    @(posedge pclk);
    cw_limit <= cw;
    ccw_limit <= counterclockwise_direction;
    pos_complete <= pc;
  endtask : pins

  task sensors(input logic [3:0] org);
    @(posedge pclk);
    org_q <= org;
  endtask : sensors
endmodule : pulse_drive_model

// *** test_pulse_output_status_bank.sv ***
// Purpose: Self-checking bench of the pulse output status bank
// Assumes: One wait state APB slave; pins settle within five edges
// Notes:   Overflow needs 2^31 steps, so it is left to the design checks
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin mismatches++; \
  $display("BAD %0t got %h exp %h", $time, g, e); end end
module test_pulse_output_status_bank;
  logic                           pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic                           irq, counter3_reset;
  logic [11:0]                    paddr;
  logic [31:0]                    pwdata, prdata, rd;
  logic [3:0]                     cw_limit, ccw_limit, pos_complete, input_word_one;
  logic [3:0]                     origin_sense, a, b, d;
  pulse_bank_pkg::chan_in_s [3:0] chan_in;
  logic [31:0]                    pv_e [4];
  logic [7:0]                     fl_e [4];
  logic [15:0]                    code_e [4];
  int                             mismatches, tests_run, ch;

  pulse_output_status_bank u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .chan_in(chan_in),
    .cw_limit(cw_limit), .ccw_limit(ccw_limit), .pos_complete(pos_complete),
    .input_word_one(input_word_one), .origin_sense(origin_sense),
    .counter3_reset(counter3_reset), .irq(irq));
  pulse_drive_model u_drv (.pclk(pclk), .chan_in(chan_in), .cw_limit(cw_limit),
    .ccw_limit(ccw_limit), .pos_complete(pos_complete), .input_word_one(input_word_one));

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  task apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) begin
      mismatches++;
      $display("BAD %0t no pready", $time);
      test_done();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task check_all();
    for (int c = 0; c < 4; c++) begin
      apb(1'b0, pulse_bank_pkg::IDX_POS_LO[c], 32'h0);
      `CHK(rd, {16'h0, pv_e[c][15:0]})
      apb(1'b0, pulse_bank_pkg::IDX_POS_HI[c], 32'h0);
      `CHK(rd, {16'h0, pv_e[c][31:16]})
      apb(1'b0, pulse_bank_pkg::IDX_STAT[c], 32'h0);
      `CHK(rd, {24'h0, fl_e[c]})
      apb(1'b0, pulse_bank_pkg::IDX_ERR[c], 32'h0);
      `CHK(rd, {16'h0, code_e[c]})
    end
  endtask : check_all

  function automatic logic [7:0] after_move(input logic [7:0] f, input logic [31:0] pv);
    after_move = f;
    after_move[pulse_bank_pkg::ST_DONE] = 1'b1;
    after_move[pulse_bank_pkg::ST_AMT] = 1'b0;
    after_move[pulse_bank_pkg::ST_ATORG] = (pv == 32'h0);
  endfunction : after_move

  task do_move(input int c, input int k, input logic counterclockwise_direction);
    u_drv.move(c, k, counterclockwise_direction, $urandom % 3);
    pv_e[c] = counterclockwise_direction ? pv_e[c] - k : pv_e[c] + k;
    fl_e[c] = after_move(fl_e[c], pv_e[c]);
  endtask : do_move

  task clear_edge(input int c);
    apb(1'b1, pulse_bank_pkg::IDX_CLR[c], 32'h1);
    pv_e[c] = 32'h0;
    fl_e[c][pulse_bank_pkg::ST_ATORG] = 1'b1;
    fl_e[c][pulse_bank_pkg::ST_SERR] = 1'b0;
    code_e[c] = 16'h0;
  endtask : clear_edge

  task test_done();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : test_done

  initial begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    $display("BAD %0t watchdog", $time);
    test_done();
  end

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    mismatches = 0;
    tests_run = 0;
    for (int c = 0; c < 4; c++) begin
      pv_e[c] = 32'h0;
      fl_e[c] = pulse_bank_pkg::FLAGS_RST;
      code_e[c] = 16'h0;
    end
    void'($urandom(78));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    check_all();
    apb(1'b0, 10'h300, 32'h0);
    `CHK(er, 1'b1)
    $display("test reset done");
    // Down through zero, then back, before random moves
    do_move(0, 1, 1'b1);
    check_all();
    do_move(0, 1, 1'b0);
    // Every channel once, channel 2 downward
    for (int c = 0; c < 4; c++) do_move(c, 2 + c, c == 2);
    repeat (6) do_move($urandom % 4, 1 + $urandom % 12, $urandom % 2);
    check_all();
    $display("test moves done");
    ch = $urandom % 4;
    clear_edge(ch);
    check_all();
    // Bit left high: no further clearing
    do_move(ch, 3, 1'b0);
    check_all();
    apb(1'b1, pulse_bank_pkg::IDX_CLR[ch], 32'h0);
    $display("test clear done");
    u_drv.ev(ch, 0, 16'h0);
    fl_e[ch][pulse_bank_pkg::ST_AMT] = 1'b1;
    fl_e[ch][pulse_bank_pkg::ST_DONE] = 1'b0;
    u_drv.level(ch, 1'b1, 1'b1);
    fl_e[ch][pulse_bank_pkg::ST_ACCEL] = 1'b1;
    fl_e[ch][pulse_bank_pkg::ST_BUSY] = 1'b1;
    fl_e[ch][pulse_bank_pkg::ST_ATORG] = 1'b0;
    check_all();
    u_drv.level(ch, 1'b0, 1'b0);
    u_drv.ev(ch, 1, 16'h0);
    fl_e[ch][7:0] = (fl_e[ch] & 8'h0E) | {1'b0, pv_e[ch] == 32'h0, 6'h0};
    check_all();
    for (int c = 0; c < 4; c++) begin
      u_drv.ev(c, 0, 16'h0);
      fl_e[c][pulse_bank_pkg::ST_AMT] = 1'b1;
      fl_e[c][pulse_bank_pkg::ST_DONE] = 1'b0;
      u_drv.ev(c, 1, 16'h0);
      fl_e[c][pulse_bank_pkg::ST_NOORG] = 1'b0;
      fl_e[c][pulse_bank_pkg::ST_SERR] = 1'b0;
    end
    check_all();
    $display("test flags done");
    apb(1'b1, pulse_bank_pkg::IDX_IMASK, 32'h1 << (8 + ch));
    code_e[ch] = 16'h0100 | 16'($urandom % 256);
    u_drv.ev(ch, 2, code_e[ch]);
    fl_e[ch][pulse_bank_pkg::ST_SERR] = 1'b1;
    check_all();
    `CHK(irq, 1'b1)
    apb(1'b1, pulse_bank_pkg::IDX_IST, 32'hFFF);
    repeat (2) @(posedge pclk);
    `CHK(irq, 1'b0)
    apb(1'b1, pulse_bank_pkg::IDX_IMASK, 32'h0);
    // Channel 0 reports code zero, kept as the fallback code
    for (int c = 0; c < 4; c++) begin
      code_e[c] = (c == 0) ? pulse_bank_pkg::SERR_FALLBACK : 16'h0100 | 16'($urandom % 256);
      u_drv.ev(c, 2, (c == 0) ? 16'h0000 : code_e[c]);
      fl_e[c][pulse_bank_pkg::ST_SERR] = 1'b1;
    end
    repeat (2) @(posedge pclk);
    `CHK(irq, 1'b0)
    clear_edge(ch);
    apb(1'b1, pulse_bank_pkg::IDX_CLR[ch], 32'h0);
    check_all();
    $display("test stop error done");
    repeat (4) begin
      a = $urandom;
      b = $urandom;
      d = $urandom;
      u_drv.pins(a, b, d);
      repeat (5) @(posedge pclk);
      for (int c = 0; c < 4; c++) begin
        apb(1'b0, pulse_bank_pkg::IDX_CLR[c], 32'h0);
        `CHK(rd[8], a[c])
        `CHK(rd[9], b[c])
        `CHK(rd[10], d[c])
      end
    end
    $display("test limits done");
    apb(1'b1, pulse_bank_pkg::IDX_CFG, 32'h3);
    // Last two passes enable one mode each
    for (int v = 0; v < 18; v++) begin
      b = (v < 16) ? 4'h3 : 4'(v - 15);
      if (v >= 16) apb(1'b1, pulse_bank_pkg::IDX_CFG, 32'(b));
      a = v[3:0] | {4{v >= 16}};
      u_drv.sensors(a);
      repeat (5) @(posedge pclk);
      `CHK(origin_sense, b[1] ? a : 4'h0)
      `CHK(counter3_reset, b[0] & a[3])
    end
    $display("test input word done");
    test_done();
  end
endmodule : test_pulse_output_status_bank
